/* src/itg_defines.svh */
`ifndef ITG_DEFINES_SVH
`define ITG_DEFINES_SVH

// Register offsets (byte addresses)
`define ITG_CTRL_OFS 8'h00
`define ITG_STATUS_OFS 8'h04
// Control bit positions and reset value
`define ITG_CTRL_EN_BIT 0
`define ITG_CTRL_TOEN_BIT 1
`define ITG_CTRL_RST 2'h0
// Status bit positions
`define ITG_ILLEGAL_BUS_CONDITION_FLAG_BIT 0
`define ITG_TX_COLLISION_FLAG_BIT 1
// Response command that answers an address match
`define ITG_CMD_ACKRESP 2'h3
// Legal byte-enable patterns
`define ITG_BE_B0 4'h1
`define ITG_BE_B1 4'h2
`define ITG_BE_B2 4'h4
`define ITG_BE_B3 4'h8
`define ITG_BE_H0 4'h3
`define ITG_BE_H1 4'hC
`define ITG_BE_W 4'hF
// Mid-frame clock-low time-out
`define ITG_TIMEOUT_US 25000
`define ITG_REF_MHZ 10
`define ITG_TIMEOUT_CYC (`ITG_TIMEOUT_US * `ITG_REF_MHZ)
// Clock pulses per byte including acknowledge
`define ITG_BYTE_PULSES 4'h9

`endif

/* src/itg_pkg.sv */
package itg_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } itg_reg_req_type;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } itg_reg_rsp_type;

  typedef enum logic [0:0] {
    ITG_MON_IDLE,
    ITG_MON_FRAME
  } itg_mon_state_type;

endpackage : itg_pkg

/* src/itg_bus_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
`include "itg_defines.svh"

module itg_bus_monitor (
  input wire logic link_clk,
  input wire logic link_rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic err_toggle,
  output logic in_frame,
  output logic scl_low
);

  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic scl_f_reg;
  logic sda_f_reg;
  logic scl_p_reg;
  logic sda_p_reg;
  itg_pkg::itg_mon_state_type state_reg;
  itg_pkg::itg_mon_state_type state_next;
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  logic byte_seen_reg;
  logic byte_seen_next;

  wire start_w = scl_f_reg && scl_p_reg && sda_p_reg && !sda_f_reg;
  wire stop_w = scl_f_reg && scl_p_reg && !sda_p_reg && sda_f_reg;
  wire rise_w = scl_f_reg && !scl_p_reg;
  // Start or stop is only legal on the first clock high after a whole byte
  wire legal_pos_w = byte_seen_reg && (bit_cnt_reg == 4'h1);
  wire in_frame_w = (state_reg == itg_pkg::ITG_MON_FRAME);
  wire illegal_w = (in_frame_w && (start_w || stop_w) && !legal_pos_w) // RULE8
                   || (!in_frame_w && stop_w); // RULE8

  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    byte_seen_next = byte_seen_reg;
    case (state_reg)
      itg_pkg::ITG_MON_IDLE: begin
        if (start_w) begin
          state_next = itg_pkg::ITG_MON_FRAME;
          bit_cnt_next = 4'h0;
          byte_seen_next = 1'b0;
        end
      end
      itg_pkg::ITG_MON_FRAME: begin
        if (stop_w) begin
          state_next = itg_pkg::ITG_MON_IDLE;
        end else if (start_w) begin
          bit_cnt_next = 4'h0;
          byte_seen_next = 1'b0;
        end else if (rise_w) begin
          bit_cnt_next = (bit_cnt_reg == `ITG_BYTE_PULSES) ? 4'h1 : bit_cnt_reg + 4'h1;
          byte_seen_next = byte_seen_reg || (bit_cnt_reg == `ITG_BYTE_PULSES - 4'h1);
        end
      end
      default: begin
        state_next = itg_pkg::ITG_MON_IDLE;
      end
    endcase
  end

  // Bus lines idle high, so the filters start high to avoid a false stop
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      scl_p_reg <= 1'b1;
      sda_p_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      if (scl_sync_reg[1] == scl_sync_reg[2]) begin
        scl_f_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[1] == sda_sync_reg[2]) begin
        sda_f_reg <= sda_sync_reg[2];
      end
      scl_p_reg <= scl_f_reg;
      sda_p_reg <= sda_f_reg;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      state_reg <= itg_pkg::ITG_MON_IDLE;
      bit_cnt_reg <= 4'h0;
      byte_seen_reg <= 1'b0;
      err_toggle <= 1'b0;
      in_frame <= 1'b0;
      scl_low <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      byte_seen_reg <= byte_seen_next;
      err_toggle <= err_toggle ^ illegal_w; // RULE8
      in_frame <= (state_next == itg_pkg::ITG_MON_FRAME);
      scl_low <= !scl_f_reg;
    end
  end

  default clocking mon_cb @(posedge link_clk); endclocking
  default disable iff (!link_rst_n);

  property p_start_stop;
    in_frame_w && !byte_seen_reg && (bit_cnt_reg == 4'h0) && stop_w |=> err_toggle != $past(err_toggle);
  endproperty
  a_start_stop: assert property (p_start_stop) else $error("start then stop not flagged"); // RULE9

  property p_legal_quiet;
    in_frame_w && legal_pos_w && (start_w || stop_w) |=> $stable(err_toggle);
  endproperty
  a_legal_quiet: assert property (p_legal_quiet) else $error("legal condition flagged"); // RULE8

  c_frame_end: cover property (in_frame_w && legal_pos_w && stop_w);

endmodule : itg_bus_monitor
`default_nettype wire

/* src/itg_status_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "itg_defines.svh"

// Contract
// RULE1: Legal 8, 16 and 32-bit lane accesses only
// RULE2: Guard lock blocks writes to protectable control
// RULE3: Collision flag shows collision on last byte
// RULE4: Collision flag raises no interrupt, only polled
// RULE5: Collision clears on match clear or ack command
// RULE6: Write one clears flag, zero leaves it
// RULE7: Bus error set regardless of bus ownership
// RULE8: Misplaced start, restart or stop is bus error
// RULE9: Controller must not send start then stop
// RULE10: Mid-frame time-out sets the bus error flag
// RULE11: Bus error clears on match clear or ack
// RULE12: Set beats simultaneous clear on any flag
module itg_status_top #(
  parameter int TIMEOUT_CYC = `ITG_TIMEOUT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic link_rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire itg_pkg::itg_reg_req_type reg_req,
  input wire logic peripheral_access_guard_lock,
  input wire logic tx_collision_event,
  input wire logic address_match_flag,
  input wire logic address_match_clear,
  input wire logic cmd_wr,
  input wire logic [1:0] response_command_field,
  output itg_pkg::itg_reg_rsp_type reg_rsp,
  output logic tx_collision_flag,
  output logic illegal_bus_condition_flag,
  output logic monitor_enable,
  output logic timeout_enable
);

  localparam int TOW = $clog2(TIMEOUT_CYC + 1);

  generate
    if (TIMEOUT_CYC < 2) begin : g_bad_timeout
      $error("TIMEOUT_CYC must be at least 2");
    end
  endgenerate

  // Link side: condition detector on its own clock
  logic mon_err_tgl;
  logic mon_in_frame;
  logic mon_scl_low;

  itg_bus_monitor u_mon (
    .link_clk(link_clk),
    .link_rst_n(link_rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .err_toggle(mon_err_tgl),
    .in_frame(mon_in_frame),
    .scl_low(mon_scl_low)
  );

  // Crossing into ref_clk: three stages, value taken once stages two and three agree
  wire [2:0] x_raw = {mon_scl_low, mon_in_frame, mon_err_tgl};
  wire [2:0] x_val;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_xing
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic v_reg;
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          v_reg <= 1'b0;
        end else begin
          s1_reg <= x_raw[gi];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            v_reg <= s3_reg;
          end
        end
      end
      assign x_val[gi] = v_reg;
    end
  endgenerate

  wire err_tgl_sync = x_val[0];
  wire frame_sync = x_val[1];
  wire scl_low_sync = x_val[2];

  logic err_seen_reg;
  wire link_err_w = err_tgl_sync ^ err_seen_reg;

  // Time-out: clock held low inside a frame
  logic [TOW-1:0] to_cnt_reg;
  logic [TOW-1:0] to_cnt_next;
  logic to_done_reg;
  logic to_done_next;
  logic [1:0] ctrl_reg;
  logic [1:0] ctrl_next;

  wire ctrl_en_w = ctrl_reg[`ITG_CTRL_EN_BIT];
  wire ctrl_toen_w = ctrl_reg[`ITG_CTRL_TOEN_BIT];
  wire stuck_w = frame_sync && scl_low_sync;
  wire to_run_w = ctrl_toen_w && stuck_w && !to_done_reg;
  wire to_hit_w = to_run_w && (to_cnt_reg == TOW'(TIMEOUT_CYC - 1)); // RULE10
  // One time-out per stall; rearms only when the stall ends
  assign to_cnt_next = to_run_w && !to_hit_w ? to_cnt_reg + TOW'(1) : '0;
  assign to_done_next = to_hit_w || (to_done_reg && stuck_w);

  // Register access decode
  wire [3:0] be_w = reg_req.be;
  wire be_ok_w = (be_w == `ITG_BE_B0) || (be_w == `ITG_BE_B1) || (be_w == `ITG_BE_B2)
                 || (be_w == `ITG_BE_B3) || (be_w == `ITG_BE_H0) || (be_w == `ITG_BE_H1)
                 || (be_w == `ITG_BE_W); // RULE1
  wire ctrl_sel_w = (reg_req.addr == `ITG_CTRL_OFS);
  wire stat_sel_w = (reg_req.addr == `ITG_STATUS_OFS);
  wire mapped_w = ctrl_sel_w || stat_sel_w;
  wire guard_block_w = reg_req.wr && ctrl_sel_w && peripheral_access_guard_lock; // RULE2
  wire req_w = reg_req.wr || reg_req.rd;
  wire req_err_w = req_w && (!be_ok_w || !mapped_w || guard_block_w);
  wire ctrl_wr_w = reg_req.wr && be_ok_w && ctrl_sel_w && !peripheral_access_guard_lock
                   && be_w[0]; // RULE2
  // Status is not protectable, so the guard is not consulted here
  wire stat_wr_w = reg_req.wr && be_ok_w && stat_sel_w && be_w[0]; // RULE2

  assign ctrl_next = ctrl_wr_w ? reg_req.wdata[1:0] : ctrl_reg;

  // Flags
  logic tx_collision_flag_reg;
  logic illegal_bus_condition_flag_reg;
  wire ack_cmd_w = cmd_wr && (response_command_field == `ITG_CMD_ACKRESP) && address_match_flag;
  wire match_clr_w = address_match_clear || ack_cmd_w; // RULE5
  wire tx_collision_flag_set_w = tx_collision_event; // RULE3
  wire tx_collision_flag_clr_w = match_clr_w || (stat_wr_w && reg_req.wdata[`ITG_TX_COLLISION_FLAG_BIT]); // RULE6
  // Any illegal condition counts, owner or not
  wire illegal_bus_condition_flag_set_w = ctrl_en_w && (link_err_w || to_hit_w); // RULE7
  wire illegal_bus_condition_flag_clr_w = match_clr_w || (stat_wr_w && reg_req.wdata[`ITG_ILLEGAL_BUS_CONDITION_FLAG_BIT]); // RULE11
  wire tx_collision_flag_next = tx_collision_flag_set_w || (tx_collision_flag_reg && !tx_collision_flag_clr_w); // RULE12
  wire illegal_bus_condition_flag_next = illegal_bus_condition_flag_set_w || (illegal_bus_condition_flag_reg && !illegal_bus_condition_flag_clr_w); // RULE12

  // Read data, with lanes outside the access reading zero
  wire [31:0] word_w = ctrl_sel_w ? {30'h0, ctrl_reg}
                     : stat_sel_w ? {30'h0, tx_collision_flag_reg, illegal_bus_condition_flag_reg} : 32'h0;
  wire [31:0] lane_w;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign lane_w[gi*8 +: 8] = be_w[gi] ? word_w[gi*8 +: 8] : 8'h00; // RULE1
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      err_seen_reg <= 1'b0;
      to_cnt_reg <= '0;
      to_done_reg <= 1'b0;
      ctrl_reg <= `ITG_CTRL_RST;
    end else begin
      err_seen_reg <= err_tgl_sync;
      to_cnt_reg <= to_cnt_next;
      to_done_reg <= to_done_next;
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_collision_flag_reg <= 1'b0;
      illegal_bus_condition_flag_reg <= 1'b0;
    end else begin
      tx_collision_flag_reg <= tx_collision_flag_next;
      illegal_bus_condition_flag_reg <= illegal_bus_condition_flag_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rsp <= '0;
    end else begin
      reg_rsp.ack <= req_w;
      reg_rsp.err <= req_err_w;
      reg_rsp.rdata <= (reg_req.rd && !req_err_w) ? lane_w : 32'h0;
    end
  end

  // Flags are only polled: no interrupt line leaves this block
  assign tx_collision_flag = tx_collision_flag_reg; // RULE4
  assign illegal_bus_condition_flag = illegal_bus_condition_flag_reg;
  assign monitor_enable = ctrl_reg[`ITG_CTRL_EN_BIT];
  assign timeout_enable = ctrl_reg[`ITG_CTRL_TOEN_BIT];

  default clocking ref_cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_tx_collision_flag_set;
    tx_collision_event |=> tx_collision_flag;
  endproperty
  a_tx_collision_flag_set: assert property (p_tx_collision_flag_set) else $error("collision not recorded"); // RULE3

  property p_set_wins;
    tx_collision_event && stat_wr_w && reg_req.wdata[`ITG_TX_COLLISION_FLAG_BIT] |=> tx_collision_flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat set"); // RULE12

  property p_w1_clear;
    reg_req.wr && reg_req.addr == `ITG_STATUS_OFS && reg_req.be == `ITG_BE_B0
      && reg_req.wdata[`ITG_TX_COLLISION_FLAG_BIT] && !tx_collision_event |=> !tx_collision_flag;
  endproperty
  a_w1_clear: assert property (p_w1_clear) else $error("write one did not clear"); // RULE6

  property p_w0_keep;
    reg_req.wr && stat_sel_w && !reg_req.wdata[`ITG_ILLEGAL_BUS_CONDITION_FLAG_BIT] && !match_clr_w
      && illegal_bus_condition_flag_reg |=> illegal_bus_condition_flag;
  endproperty
  a_w0_keep: assert property (p_w0_keep) else $error("write zero changed flag"); // RULE6

  property p_match_clr;
    (address_match_clear || (cmd_wr && response_command_field == 2'h3 && address_match_flag))
      && !tx_collision_event |=> !tx_collision_flag;
  endproperty
  a_match_clr: assert property (p_match_clr) else $error("collision kept after match clear"); // RULE5

  property p_cmd_illegal_bus_condition_flag;
    cmd_wr && response_command_field == 2'h3 && address_match_flag && !illegal_bus_condition_flag_set_w
      |=> !illegal_bus_condition_flag;
  endproperty
  a_cmd_illegal_bus_condition_flag: assert property (p_cmd_illegal_bus_condition_flag) else $error("bus error kept after command"); // RULE11

  property p_guard;
    reg_req.wr && ctrl_sel_w && peripheral_access_guard_lock |=> $stable(ctrl_reg) ##0 reg_rsp.err;
  endproperty
  a_guard: assert property (p_guard) else $error("guarded write took effect"); // RULE2

  property p_bad_size;
    reg_req.wr && ctrl_sel_w && !be_ok_w |=> $stable(ctrl_reg) ##0 reg_rsp.ack && reg_rsp.err;
  endproperty
  a_bad_size: assert property (p_bad_size) else $error("illegal lane pattern accepted"); // RULE1

  property p_link_err;
    ctrl_en_w && $changed(err_tgl_sync) |=> illegal_bus_condition_flag;
  endproperty
  a_link_err: assert property (p_link_err) else $error("illegal condition not flagged"); // RULE7

  property p_timeout;
    to_hit_w && ctrl_en_w |=> illegal_bus_condition_flag ##0 to_done_reg;
  endproperty
  a_timeout: assert property (p_timeout) else $error("time-out not flagged"); // RULE10

  c_tx_collision_flag: cover property (tx_collision_event ##1 tx_collision_flag ##[1:20] !tx_collision_flag);
  c_illegal_bus_condition_flag: cover property (link_err_w && ctrl_en_w);
  c_timeout: cover property (to_hit_w);
  c_guard: cover property (guard_block_w);

endmodule : itg_status_top
`default_nettype wire

/* verification/itg_i2c_ctrl_model.sv */
`timescale 1ns/1ns
`default_nettype none

// Bus controller at the far side; lines rest high through the pull-ups.
// Each level is held 200 ns, well over three link clocks.
module itg_i2c_ctrl_model (
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // Expects SCL high on entry
  task automatic cond_start;
    sda = 1'b0;
    #200;
  endtask : cond_start

  // Bare rising SDA with SCL high
  task automatic stop_now;
    sda = 1'b1;
    #200;
  endtask : stop_now

  task automatic scl_low;
    scl = 1'b0;
    #200;
  endtask : scl_low

  // Data changes only while SCL is low; acknowledge slot left to the pull-up
  task automatic pulses(input int n, input logic [7:0] data);
    for (int i = 0; i < n; i++) begin
      scl = 1'b0;
      sda = (i < 8) ? data[7 - i] : 1'b1;
      #200;
      scl = 1'b1;
      #200;
    end
  endtask : pulses

  // Ordinary stop: SDA low under SCL low, then rise with SCL high
  task automatic stop;
    scl = 1'b0;
    sda = 1'b0;
    #200;
    scl = 1'b1;
    #200;
    sda = 1'b1;
    #200;
  endtask : stop
endmodule : itg_i2c_ctrl_model

`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic ref_clk, rst_n, link_clk, link_rst_n, scl, sda, lock, tx_collision_flag_ev, am_flag, am_clr, cmd_wr;
  logic [1:0] cmd;
  logic tx_collision_flag_f, bus_f, mon_en, to_en;
  itg_pkg::itg_reg_req_type req;
  itg_pkg::itg_reg_rsp_type rsp, got;
  int miscompares = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h11;
  logic [3:0] bes [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};

  itg_status_top #(.TIMEOUT_CYC(50)) itg_status_top_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk), .link_rst_n(link_rst_n),
    .scl_in(scl), .sda_in(sda), .reg_req(req), .peripheral_access_guard_lock(lock),
    .tx_collision_event(tx_collision_flag_ev), .address_match_flag(am_flag),
    .address_match_clear(am_clr), .cmd_wr(cmd_wr), .response_command_field(cmd),
    .reg_rsp(rsp), .tx_collision_flag(tx_collision_flag_f), .illegal_bus_condition_flag(bus_f),
    .monitor_enable(mon_en), .timeout_enable(to_en)
  );
  itg_i2c_ctrl_model itg_i2c_ctrl_model_i (.scl(scl), .sda(sda));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  function automatic logic [31:0] status_exp(input logic c, input logic b);
    return {30'h0, c, b};
  endfunction : status_exp

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  // Request held one cycle; answer sampled just after the taking edge
  task automatic acc(input logic wr, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    @(posedge ref_clk);
    req <= {wr, ~wr, a, be, d};
    @(posedge ref_clk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    #1 got = rsp;
  endtask : acc

  task automatic side(input logic ev, input logic clr, input logic cw, input logic [1:0] c);
    @(posedge ref_clk);
    tx_collision_flag_ev <= ev;
    am_clr <= clr;
    cmd_wr <= cw;
    cmd <= c;
    @(posedge ref_clk);
    tx_collision_flag_ev <= 1'b0;
    am_clr <= 1'b0;
    cmd_wr <= 1'b0;
    #1;
  endtask : side

  task automatic waitc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : waitc

  initial begin
    rst_n = 1'b0;
    link_rst_n = 1'b0;
    req = '0;
    lock = 1'b0;
    tx_collision_flag_ev = 1'b0;
    am_flag = 1'b0;
    am_clr = 1'b0;
    cmd_wr = 1'b0;
    cmd = 2'h0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    link_rst_n <= 1'b1;
    waitc(10);
    check({28'h0, tx_collision_flag_f, bus_f, mon_en, to_en}, 32'h0);
    foreach (bes[i]) begin
      acc(1'b0, 8'h04, bes[i], 32'h0);
      check({30'h0, got.ack, got.err}, 32'h2);
    end
    acc(1'b0, 8'h04, 4'h5, 32'h0);
    check({30'h0, got.ack, got.err}, 32'h3);
    acc(1'b0, 8'h08, 4'hF, 32'h0);
    check({30'h0, got.ack, got.err}, 32'h3);
    seed = xs(seed);
    acc(1'b1, 8'h00, 4'h1, {seed[31:8], 8'h03});
    check({30'h0, mon_en, to_en}, 32'h3);
    acc(1'b0, 8'h00, 4'hF, 32'h0);
    check(got.rdata, 32'h3);
    acc(1'b1, 8'h00, 4'h2, 32'h0);
    check({30'h0, mon_en, to_en}, 32'h3);
    acc(1'b1, 8'h00, 4'h5, 32'h0);
    check({28'h0, got.ack, got.err, mon_en, to_en}, 32'hF);
    @(posedge ref_clk);
    lock <= 1'b1;
    acc(1'b1, 8'h00, 4'h1, 32'h0);
    check({28'h0, got.ack, got.err, mon_en, to_en}, 32'hF);
    acc(1'b1, 8'h04, 4'h1, 32'h1);
    check({30'h0, got.ack, got.err}, 32'h2);
    lock <= 1'b0;
    side(1'b1, 1'b0, 1'b0, 2'h0);
    check({31'h0, tx_collision_flag_f}, 32'h1);
    acc(1'b0, 8'h04, 4'hF, 32'h0);
    check(got.rdata, status_exp(1'b1, 1'b0));
    acc(1'b1, 8'h04, 4'h1, 32'h0);
    check({31'h0, tx_collision_flag_f}, 32'h1);
    acc(1'b1, 8'h04, 4'h1, 32'h2);
    check({31'h0, tx_collision_flag_f}, 32'h0);
    @(posedge ref_clk);
    tx_collision_flag_ev <= 1'b1;
    req <= {1'b1, 1'b0, 8'h04, 4'h1, 32'h2};
    @(posedge ref_clk);
    tx_collision_flag_ev <= 1'b0;
    req.wr <= 1'b0;
    #1 check({31'h0, tx_collision_flag_f}, 32'h1);
    side(1'b0, 1'b1, 1'b0, 2'h0);
    check({31'h0, tx_collision_flag_f}, 32'h0);
    am_flag <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      side(1'b1, 1'b0, 1'b0, 2'h0);
      side(1'b0, 1'b0, 1'b1, (i == 0) ? 2'h3 : seed[1:0]);
      check({31'h0, tx_collision_flag_f}, {31'h0, (i != 0) && (seed[1:0] != 2'h3)});
      acc(1'b1, 8'h04, 4'h1, 32'h2);
    end
    am_flag <= 1'b0;
    itg_i2c_ctrl_model_i.cond_start();
    itg_i2c_ctrl_model_i.pulses(9, seed[7:0]);
    itg_i2c_ctrl_model_i.stop();
    waitc(15);
    check({31'h0, bus_f}, 32'h0);
    itg_i2c_ctrl_model_i.cond_start();
    itg_i2c_ctrl_model_i.stop_now();
    waitc(15);
    check({31'h0, bus_f}, 32'h1);
    acc(1'b1, 8'h04, 4'h1, 32'h0);
    check({31'h0, bus_f}, 32'h1);
    acc(1'b1, 8'h04, 4'h1, 32'h1);
    check({31'h0, bus_f}, 32'h0);
    itg_i2c_ctrl_model_i.cond_start();
    itg_i2c_ctrl_model_i.pulses(3, 8'hA5);
    itg_i2c_ctrl_model_i.stop();
    waitc(15);
    check({31'h0, bus_f}, 32'h1);
    side(1'b0, 1'b1, 1'b0, 2'h0);
    check({31'h0, bus_f}, 32'h0);
    itg_i2c_ctrl_model_i.cond_start();
    itg_i2c_ctrl_model_i.stop_now();
    waitc(15);
    am_flag <= 1'b1;
    side(1'b0, 1'b0, 1'b1, 2'h3);
    check({31'h0, bus_f}, 32'h0);
    am_flag <= 1'b0;
    itg_i2c_ctrl_model_i.cond_start();
    itg_i2c_ctrl_model_i.scl_low();
    waitc(30);
    check({31'h0, bus_f}, 32'h0);
    waitc(40);
    check({31'h0, bus_f}, 32'h1);
    itg_i2c_ctrl_model_i.stop();
    results();
  end

  // Tests need well under 10000 cycles
  initial begin
    #3000000;
    miscompares++;
    results();
  end
endmodule : testbench

`default_nettype wire
